/* verilog/slc_stack_checker.v */
/*
 * Stack limit checker: working stack pointer, upper bound register, push word
 * builder and stack error trap logic.
 * Assumes the core issues at most one stack operation per cycle, that all
 * inputs are synchronous to mclk, and that the core holds off new requests
 * while push_hi_pending is high.
 */
`timescale 1ns/10ps
`default_nettype none
`include "slc_map.vh"

module slc_stack_checker #(
    parameter AW = `SLC_AW,
    parameter PCW = `SLC_PC_W
) (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Stack operation requests from the core
    input wire push_req,
    input wire pop_req,
    input wire [1:0] push_kind,
    input wire [AW-1:0] push_data,
    input wire [PCW-1:0] pc_value,
    input wire [`SLC_STAT_W-1:0] status_low_byte,
    // Other pointer effective addresses generated with the stack pointer
    input wire ea_valid,
    input wire [AW-1:0] ea_addr,
    // Direct writes from software
    input wire sp_wr,
    input wire [AW-1:0] sp_wdata,
    input wire bound_wr,
    input wire [AW-1:0] bound_wdata,
    input wire trap_clr,
    // Memory side
    output reg mem_wr,
    output reg mem_rd,
    output reg [AW-1:0] mem_addr,
    output reg [AW-1:0] mem_wdata,
    // State and traps
    output wire [AW-1:0] stack_pointer_working_reg,
    output wire [AW-1:0] stack_upper_bound,
    output reg trap_req,
    output reg overflow_flag,
    output reg underflow_flag,
    output wire push_hi_pending
);

    // Step by one word
    // Byte-sized stack moves do not exist, so the step is fixed
    localparam [AW-1:0] STEP = `SLC_STEP;
    // Low part of the return address, high part width
    localparam HIW = PCW - AW;

    // Stack pointer and upper bound
    reg [AW-1:0] sp_reg;
    reg [AW-1:0] bound_reg;
    // Second push word owed by a return-address push
    reg hi_pend_reg;
    reg [AW-1:0] hi_word_reg;
    // Combinational next values
    reg [AW-1:0] sp_next;
    reg [AW-1:0] ea_now;
    reg ea_push;
    reg ea_pop;
    reg [AW-1:0] wdata_now;
    wire over_hit;
    wire under_hit;
    wire any_hit;

    // Aligned address, since bit zero never matters
    // Shared by the bound, pointer loads and indirect addresses
    function [AW-1:0] align;
        input [AW-1:0] a;
        begin
            align = {a[AW-1:1], 1'b0};
        end
    endfunction

    // High return word for call and exception pushes
    function [AW-1:0] hi_word;
        input [1:0] kind;
        input [PCW-1:0] pc;
        input [`SLC_STAT_W-1:0] stat_byte;
        reg [AW-1:0] w;
        begin
            // Bits between the status byte and the PC top stay zero
            w = {AW{1'b0}};
            w[HIW-1:0] = pc[PCW-1:AW];
            if (kind == `SLC_PK_EXC) begin
                w[AW-1:AW-`SLC_STAT_W] = stat_byte;
            end
            if (kind == `SLC_PK_CALL) begin
                w[`SLC_HI_MSB] = 1'b0;
            end
            hi_word = w;
        end
    endfunction

    assign stack_pointer_working_reg = sp_reg;
    assign stack_upper_bound = align(bound_reg);
    assign push_hi_pending = hi_pend_reg;

    // Address and pointer update for this cycle
    // Priority: owed high word, push, pop, indirect check, pointer load.
    // Lower requests in the same cycle are dropped without notice, so the
    // core must never stack two of them in one cycle.
    always @* begin
        sp_next = sp_reg;
        ea_now = sp_reg;
        ea_push = 1'b0;
        ea_pop = 1'b0;
        wdata_now = push_data;
        if (hi_pend_reg) begin
            // Second word of a return push owns the cycle
            ea_push = 1'b1;
            wdata_now = hi_word_reg;
            // Pointer moves past the high word as well
            sp_next = sp_reg + STEP;
        end else if (push_req) begin
            ea_push = 1'b1;
            wdata_now = (push_kind == `SLC_PK_DATA) ? push_data : pc_value[AW-1:0];
            sp_next = sp_reg + STEP;
        end else if (pop_req) begin
            ea_pop = 1'b1;
            ea_now = sp_reg - STEP;
            sp_next = sp_reg - STEP;
        end else if (ea_valid) begin
            // Indirect access through the pointer, checked without moving it
            ea_pop = 1'b1;
            ea_now = align(ea_addr);
        end else if (sp_wr) begin
            // Direct load, bit zero dropped to keep the pointer aligned
            sp_next = align(sp_wdata);
        end
    end

    // One comparator serves push, pop and indirect addresses alike
    // Every pointer address compared
    slc_bound_cmp #(.AW(AW)) u_cmp (
        .ea(ea_now),
        .is_push(ea_push),
        .is_pop(ea_pop),
        .upper_bound(stack_upper_bound),
        .over(over_hit),
        .under(under_hit)
    );

    // Either hit raises the same request to the exception logic
    // Past-bound push traps
    assign any_hit = over_hit | under_hit;

    // Until software loads it the bound is unknown, so a push made
    // before the first load may report an unknown overflow
    // No reset on the bound
    always @(posedge mclk) begin
        if (bound_wr) begin
            bound_reg <= align(bound_wdata);
        end
    end

    // Pointer, memory strobes and trap flags
    // Strobes are registered, so the word lands one cycle after the
    // request edge while the pointer has already moved
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // Pointer starts on the floor, the first legal free word
            sp_reg <= `SLC_SP_RST;
            hi_pend_reg <= 1'b0;
            hi_word_reg <= {AW{1'b0}};
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            mem_addr <= {AW{1'b0}};
            mem_wdata <= {AW{1'b0}};
            trap_req <= 1'b0;
            overflow_flag <= 1'b0;
            underflow_flag <= 1'b0;
        end else begin
            sp_reg <= sp_next;
            // Return pushes take a second cycle for the high word
            hi_pend_reg <= ~hi_pend_reg & push_req & (push_kind != `SLC_PK_DATA);
            // High word captured with the low one, since the core may
            // change the program counter right after the request
            if (push_req & ~hi_pend_reg) begin
                hi_word_reg <= hi_word(push_kind, pc_value, status_low_byte);
            end
            // Strobes and address follow the request by one cycle
            mem_wr <= ea_push;
            mem_rd <= ea_pop;
            mem_addr <= ea_now;
            mem_wdata <= wdata_now;
            trap_req <= any_hit;
            // A hit in the clearing cycle beats the clear, so no trap is
            // lost between software reading and clearing a flag
            // Sticky flags, set wins
            overflow_flag <= over_hit | (overflow_flag & ~trap_clr);
            underflow_flag <= under_hit | (underflow_flag & ~trap_clr);
        end
    end

endmodule
`default_nettype wire

/* verilog/slc_map.vh */
/*
 * Constants for the stack limit checker: widths, reset values, fixed floor,
 * and push word layout.
 * Assumes a 16-bit data space with byte addresses and word-aligned stack.
 */
`ifndef SLC_MAP_VH
`define SLC_MAP_VH

// Address and data width
`define SLC_AW 16
// Underflow floor, stack below this would hit the control register region
`define SLC_FLOOR 16'h0800
// Stack pointer reset value, the first legal free word
`define SLC_SP_RST 16'h0800
// Stack step in bytes for one word
`define SLC_STEP 16'h0002
// Word alignment bit position
`define SLC_ALIGN_BIT 0
// Top bit of the high return word
`define SLC_HI_MSB 15
// Width of the status low byte
`define SLC_STAT_W 8
// Program counter width
`define SLC_PC_W 23
// Push kinds
`define SLC_PK_DATA 2'h0
`define SLC_PK_CALL 2'h1
`define SLC_PK_EXC 2'h2

`endif

/* verilog/slc_bound_cmp.v */
/*
 * Bound comparator for one stack effective address.
 * Assumes the address and bound are already word aligned; pure combinational.
 */
`timescale 1ns/10ps
`default_nettype none
`include "slc_map.vh"

module slc_bound_cmp #(
    parameter AW = `SLC_AW
) (
    // Address under test
    input wire [AW-1:0] ea,
    input wire is_push,
    input wire is_pop,
    // Limits
    input wire [AW-1:0] upper_bound,
    // Results
    output wire over,
    output wire under
);

    // Push beyond the bound; a push at the bound itself is still legal
    assign over = is_push & (ea > upper_bound);
    // Any stack access that lands below the floor
    assign under = (is_push | is_pop) & (ea < `SLC_FLOOR);

endmodule
`default_nettype wire

/* verif/slc_props.sv */
/* Stack checker assertions.
   Sees the top's ports only. */
`timescale 1ns/10ps
`default_nettype none
`include "slc_map.vh"
module slc_props (input wire logic mclk, arst_n, push_req, pop_req, ea_valid, mem_wr, mem_rd, trap_req,
    overflow_flag, underflow_flag, push_hi_pending, trap_clr, input wire logic [1:0] push_kind,
    input wire logic [15:0] mem_addr, mem_wdata, stack_pointer_working_reg, stack_upper_bound, ea_addr,
    input wire logic [22:0] pc_value);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Push and pop as taken
    wire [15:0] sp = stack_pointer_working_reg;
    wire ps = push_req && !push_hi_pending;
    wire pp = pop_req && !push_req && !push_hi_pending;
    bit0_zero_a: assert property (!stack_upper_bound[0]) else $error("bit0");
    push_wr_a: assert property (ps && push_kind == `SLC_PK_DATA |=> mem_wr &&
        mem_addr == $past(sp) && sp == mem_addr + 16'h0002) else $error("push");
    pop_rd_a: assert property (pp |=> mem_rd && sp == $past(sp) - 16'h0002 && mem_addr == sp)
        else $error("pop");
    over_trap_a: assert property (ps && sp > stack_upper_bound && sp >= `SLC_FLOOR |=>
        trap_req && overflow_flag) else $error("over");
    under_trap_a: assert property (pp && sp < `SLC_FLOOR + 2 |=> trap_req && underflow_flag)
        else $error("under");
    ea_floor_a: assert property (ea_valid && !push_req && !pop_req && !push_hi_pending &&
        ea_addr < `SLC_FLOOR |=> trap_req) else $error("ea");
    call_hi_a: assert property (ps && push_kind == `SLC_PK_CALL |-> ##2
        mem_wdata == {9'h000, $past(pc_value[22:16], 2)}) else $error("call");
    flag_hold_a: assert property (underflow_flag && !trap_clr |=> underflow_flag) else $error("flag");
    cover property (ps && push_kind == `SLC_PK_EXC);
    cover property (trap_req && overflow_flag);
    cover property (trap_req && underflow_flag);
endmodule
bind slc_stack_checker slc_props props (.mclk(mclk), .arst_n(arst_n), .push_req(push_req), .pop_req(pop_req),
    .ea_valid(ea_valid), .mem_wr(mem_wr), .mem_rd(mem_rd), .trap_req(trap_req), .overflow_flag(overflow_flag),
    .underflow_flag(underflow_flag), .push_hi_pending(push_hi_pending), .trap_clr(trap_clr),
    .push_kind(push_kind), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .stack_pointer_working_reg(stack_pointer_working_reg), .stack_upper_bound(stack_upper_bound),
    .ea_addr(ea_addr), .pc_value(pc_value));
`default_nettype wire

/* verif/slc_core_mem.sv */
/* Core-side memory model: stores pushed words.
   Assumes one write per clock. */
`timescale 1ns/10ps
`default_nettype none
module slc_core_mem (input wire logic mclk, mem_wr, input wire logic [15:0] mem_addr, mem_wdata);
    // Word store, whole data space
    logic [15:0] word [0:65535];
    // Word lands where the pointer aimed
    always @(posedge mclk) if (mem_wr) word[mem_addr] <= mem_wdata;
endmodule
`default_nettype wire

/* verif/tb.sv */
/* Bench: reset, scenario tasks, verdict.
   Assumes the checker is bound. */
`timescale 1ns/10ps
`default_nettype none
`include "slc_map.vh"
module tb;
    // Request codes: push, pop, address, pointer, bound, clear
    localparam logic [5:0] P = 6'h20, Q = 6'h10, E = 6'h08, S = 6'h04, B = 6'h02, C = 6'h01;
    logic mclk = 1'h0, arst_n = 1'h0, push_req = 1'h0, pop_req = 1'h0;
    logic ea_valid = 1'h0, sp_wr = 1'h0, bound_wr = 1'h0, trap_clr = 1'h0;
    logic [1:0] push_kind = 2'h0;
    logic [15:0] d = 16'h0000;
    logic [22:0] pc_value = 23'h7f1234;
    logic [7:0] status_low_byte = 8'ha5;
    wire mem_wr, mem_rd, trap_req, overflow_flag, underflow_flag, push_hi_pending;
    wire [15:0] mem_addr, mem_wdata, stack_pointer_working_reg, stack_upper_bound;
    int error_cnt = 0, samples_checked = 0;
    always #2 mclk = ~mclk;
    slc_stack_checker dut (.mclk(mclk), .arst_n(arst_n), .push_req(push_req), .pop_req(pop_req),
        .push_kind(push_kind), .push_data(d), .pc_value(pc_value), .status_low_byte(status_low_byte),
        .ea_valid(ea_valid), .ea_addr(d), .sp_wr(sp_wr), .sp_wdata(d), .bound_wr(bound_wr), .bound_wdata(d),
        .trap_clr(trap_clr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .stack_pointer_working_reg(stack_pointer_working_reg), .stack_upper_bound(stack_upper_bound),
        .trap_req(trap_req), .overflow_flag(overflow_flag), .underflow_flag(underflow_flag),
        .push_hi_pending(push_hi_pending));
    slc_core_mem m (.mclk(mclk), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
    task chk(input logic [15:0] s, e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    // One request held for one edge
    task op(input logic [5:0] c, input logic [15:0] v);
        @(negedge mclk);
        {push_req, pop_req, ea_valid, sp_wr, bound_wr, trap_clr} = c;
        d = v;
        @(negedge mclk);
        {push_req, pop_req, ea_valid, sp_wr, bound_wr, trap_clr} = 6'h00;
    endtask
    task t_base;
        op(B, 16'h0901);
        chk(stack_upper_bound, 16'h0900);
        op(P, 16'h1234);
        chk(mem_addr, 16'h0800);
        chk(stack_pointer_working_reg, 16'h0802);
        op(Q, 16'h0000);
        chk(trap_req, 1'h0);
        chk(mem_rd, 1'h1);
        chk(mem_addr, 16'h0800);
        op(Q, 16'h0000);
        chk(trap_req, 1'h1);
        @(negedge mclk);
        chk({trap_req, underflow_flag}, 2'h1);
        op(C, 16'h0000);
        chk(underflow_flag, 1'h0);
        $display("base end");
    endtask
    task t_lim;
        op(S, 16'h0900);
        op(P, 16'h0001);
        chk(trap_req, 1'h0);
        op(P, 16'h0002);
        chk({trap_req, overflow_flag}, 2'h3);
        op(E, 16'h0400);
        chk(trap_req, 1'h1);
        $display("limit end");
    endtask
    task t_ret;
        op(S, 16'h0820);
        push_kind = `SLC_PK_CALL;
        op(P, 16'h0000);
        chk(push_hi_pending, 1'h1);
        @(negedge mclk);
        chk(mem_wdata, 16'h007f);
        chk(m.word[16'h0820], 16'h1234);
        push_kind = `SLC_PK_EXC;
        op(P, 16'h0000);
        @(negedge mclk);
        chk(mem_wdata, 16'ha57f);
        chk(stack_pointer_working_reg, 16'h0828);
        $display("return end");
    endtask
    // Mid-run reset: pointer and flags restart, the bound survives
    task t_rst;
        @(negedge mclk);
        arst_n = 1'h0;
        @(negedge mclk);
        chk(stack_pointer_working_reg, `SLC_SP_RST);
        chk({trap_req, overflow_flag, underflow_flag}, 3'h0);
        chk(stack_upper_bound, 16'h0900);
        arst_n = 1'h1;
        push_kind = `SLC_PK_DATA;
        op(P, 16'h5678);
        chk(mem_wr, 1'h1);
        chk(mem_addr, 16'h0800);
        chk(stack_pointer_working_reg, 16'h0802);
        $display("reset end");
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        arst_n = 1'h1;
        t_base;
        t_lim;
        t_ret;
        t_rst;
        conclude;
    end
    // Watchdog, far beyond the run
    initial begin
        #2000;
        error_cnt++;
        conclude;
    end
endmodule
`default_nettype wire
